// >>> hw/adsc_pkg.sv
package adsc_pkg;

  // Clock period of the system domain, in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned NS_PER_US = 1000;

  // Longest conversion times, in microseconds.
  localparam int unsigned VOLT_MAX_US = 9;
  localparam int unsigned TEMP_REF_ON_MAX_US = 65;
  localparam int unsigned TEMP_REF_OFF_MAX_US = 140;

  // Longest times as clock counts, rounded down.
  localparam int unsigned VOLT_MAX_CYCLES = (VOLT_MAX_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int unsigned TEMP_ON_CYCLES = (TEMP_REF_ON_MAX_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int unsigned TEMP_OFF_CYCLES = (TEMP_REF_OFF_MAX_US * NS_PER_US) / CLK_PERIOD_NS;

  // Conversion clock: cycles per voltage conversion and its period in clocks.
  localparam int unsigned CONV_CLOCKS = 15;
  localparam int unsigned CONV_CLK_DIV = VOLT_MAX_CYCLES / CONV_CLOCKS;
  localparam int unsigned TIMER_W = 12;

  // Data widths and power-up codes.
  localparam int unsigned DAC_BITS = 12;
  localparam int unsigned DAC_CHANNELS = 4;
  localparam logic [11:0] DAC_FULL = 12'hfff;
  localparam logic [11:0] DAC_ZERO = 12'h000;
  localparam int unsigned CMD_BITS = 8;
  localparam int unsigned RESULT_BITS = 16;
  localparam logic [3:0] RESULT_PAD = 4'h0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [4:0] OUT_END = 5'h10;
  localparam logic [1:0] INIT_LOAD = 2'h3;

  // Conversion clock modes.
  localparam logic [1:0] CKMODE_00 = 2'h0;
  localparam logic [1:0] CKMODE_01 = 2'h1;
  localparam logic [1:0] CKMODE_10 = 2'h2;
  localparam logic [1:0] CKMODE_11 = 2'h3;

  // One byte received on the serial input.
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } adsc_serial_byte_t;

  // One write to a DAC input register.
  typedef struct packed {
    logic [1:0] channel;
    logic [11:0] code;
  } adsc_dac_write_t;

endpackage

// >>> hw/adsc_serial_pin_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

module adsc_serial_pin_ctrl
  import adsc_pkg::*;
(
  // System clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Serial link from the host, clocked by the host.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // Conversion control and status pins.
  input wire logic conversion_start_n,
  input wire logic [1:0] conversion_clock_mode,
  input wire logic conv_is_temp,
  input wire logic ref_on,
  input wire logic [DAC_BITS-1:0] sample_data,
  output logic eoc_n,
  // Received bytes toward the command decoder.
  output adsc_serial_byte_t command_byte,
  output logic command_valid,
  // DAC register writes from the command decoder.
  input wire logic dac_write_valid,
  input wire adsc_dac_write_t dac_write,
  // DAC load and wake pins, and DAC codes.
  input wire logic dac_load_n,
  input wire logic dac_wake_select,
  output logic dac_wake_to_ref,
  output logic [DAC_CHANNELS-1:0][DAC_BITS-1:0] dac_outputs
);

  // ---------------- Serial clock domain ----------------

  logic [2:0] bit_cnt; // Position within the current byte.
  logic [2:0] next_bit_cnt;
  logic [6:0] in_shift; // Bits of the byte gathered so far.
  logic [6:0] next_in_shift;
  logic first_done; // Set once the command byte has passed.
  logic next_first_done;
  logic byte_done; // The eighth bit is on the input now.
  adsc_serial_byte_t byte_hold; // Last whole byte, stable for the crossing.
  adsc_serial_byte_t next_byte_hold;
  logic byte_toggle; // Flips once per received byte.
  logic next_byte_toggle;
  logic [4:0] out_idx_fall; // Output bit index advanced on falling edges.
  logic [4:0] next_out_idx_fall;
  logic [4:0] out_idx_rise; // Output bit index advanced on rising edges.
  logic [4:0] next_out_idx_rise;
  logic [4:0] out_idx; // Index chosen by the clock mode.
  logic [RESULT_BITS-1:0] result_word; // Result as shifted out.

  // Gather input bits; a high select holds this state cleared.
  always_comb begin
    byte_done = !cs_n && (bit_cnt == LAST_BIT);
    next_bit_cnt = bit_cnt + 3'h1;
    next_in_shift = {in_shift[5:0], din};
    next_first_done = first_done | byte_done;
  end

  // Select high acts as reset so every frame starts on a command byte.
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= 3'h0;
      in_shift <= 7'h00;
      first_done <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      in_shift <= next_in_shift;
      first_done <= next_first_done;
    end
  end

  // The byte holder is not cleared by select, so a frame end makes no
  // spurious toggle for the system domain to see.
  always_comb begin
    next_byte_hold = byte_hold;
    next_byte_toggle = byte_toggle;
    if (byte_done) begin
      next_byte_hold = '{first: !first_done, data: {in_shift, din}};
      next_byte_toggle = !byte_toggle;
    end
  end

  // Registers the finished byte and its toggle.
  always_ff @(negedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      byte_hold <= '0;
      byte_toggle <= 1'b0;
    end else begin
      byte_hold <= next_byte_hold;
      byte_toggle <= next_byte_toggle;
    end
  end

  // Output indices saturate once the whole word is out.
  always_comb begin
    next_out_idx_fall = out_idx_fall;
    next_out_idx_rise = out_idx_rise;
    if (out_idx_fall != OUT_END) begin
      next_out_idx_fall = out_idx_fall + 5'h01;
    end
    if (out_idx_rise != OUT_END) begin
      next_out_idx_rise = out_idx_rise + 5'h01;
    end
  end

  // Falling-edge output index.
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_idx_fall <= 5'h00;
    end else begin
      out_idx_fall <= next_out_idx_fall;
    end
  end

  // Rising-edge output index.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_idx_rise <= 5'h00;
    end else begin
      out_idx_rise <= next_out_idx_rise;
    end
  end

  // The clock mode is a static setting, so the choice between the two
  // indices never changes inside a frame.
  always_comb begin
    if (conversion_clock_mode == CKMODE_11) begin
      out_idx = out_idx_rise;
    end else begin
      out_idx = out_idx_fall;
    end
  end

  // The result word is read straight from the system domain. It only
  // changes at a conversion end, which the host must wait out before
  // taking select low, so it stands still across any frame.
  always_comb begin
    if (out_idx == OUT_END) begin
      dout = 1'b0;
    end else begin
      dout = result_word[RESULT_BITS - 1 - 32'(out_idx)];
    end
    dout_oe = !cs_n;
  end

  // ---------------- System clock domain ----------------

  typedef enum {ADSC_IDLE, ADSC_RUN} adsc_conv_state_t;

  logic [1:0] cs_sync; // Select synchroniser.
  logic cs_prev; // Select one cycle later, for edges.
  logic [1:0] start_sync; // Conversion start synchroniser.
  logic start_prev;
  logic [1:0] wake_sync; // Wake strap synchroniser.
  logic [1:0] tog_sync; // Byte toggle synchroniser.
  logic tog_prev;
  logic cs_fall; // Host began reading.
  logic start_rise; // Conversion start released.

  // Select, start, the wake strap and the link toggle pass two flops before use.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_sync <= 2'h3;
      cs_prev <= 1'b1;
      start_sync <= 2'h3;
      start_prev <= 1'b1;
      wake_sync <= 2'h0;
      tog_sync <= 2'h0;
      tog_prev <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], cs_n};
      cs_prev <= cs_sync[1];
      start_sync <= {start_sync[0], conversion_start_n};
      start_prev <= start_sync[1];
      wake_sync <= {wake_sync[0], dac_wake_select};
      tog_sync <= {tog_sync[0], byte_toggle};
      tog_prev <= tog_sync[1];
    end
  end

  assign cs_fall = cs_prev && !cs_sync[1];
  // Start edge is the rising edge; pulse width is the host's duty.
  assign start_rise = !start_prev && start_sync[1];

  adsc_conv_state_t conv_state;
  adsc_conv_state_t next_conv_state;
  logic [TIMER_W-1:0] timer; // Cycles left in the conversion.
  logic [TIMER_W-1:0] next_timer;
  logic next_eoc_n;
  logic [DAC_BITS-1:0] result; // Last conversion result.
  logic [DAC_BITS-1:0] next_result;
  logic [TIMER_W-1:0] duration; // Length of the conversion starting now.

  // Voltage conversions run a fixed number of conversion clocks; the
  // temperature lengths are held to their longest allowed values.
  always_comb begin
    if (!conv_is_temp) begin
      duration = TIMER_W'(CONV_CLOCKS * CONV_CLK_DIV - 1);
    end else if (ref_on) begin
      duration = TIMER_W'(TEMP_ON_CYCLES - 1);
    end else begin
      duration = TIMER_W'(TEMP_OFF_CYCLES - 1);
    end
  end

  // Conversion sequencer and end-of-conversion flag.
  always_comb begin
    next_conv_state = conv_state;
    next_timer = timer;
    next_result = result;
    next_eoc_n = eoc_n;
    if (cs_fall) begin
      next_eoc_n = 1'b1;
    end
    unique case (conv_state)
      ADSC_IDLE: begin
        if (start_rise) begin
          next_conv_state = ADSC_RUN;
          next_timer = duration;
          next_eoc_n = 1'b1;
        end
      end
      ADSC_RUN: begin
        if (timer == '0) begin
          // The fall wins over a read start in the same cycle.
          next_conv_state = ADSC_IDLE;
          next_result = sample_data;
          next_eoc_n = 1'b0;
        end else begin
          next_timer = timer - TIMER_W'(1);
        end
      end
    endcase
  end

  // Registers the sequencer.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_state <= ADSC_IDLE;
      timer <= '0;
      result <= DAC_ZERO;
      eoc_n <= 1'b1;
    end else begin
      conv_state <= next_conv_state;
      timer <= next_timer;
      result <= next_result;
      eoc_n <= next_eoc_n;
    end
  end

  assign result_word = {RESULT_PAD, result};

  logic next_command_valid;
  adsc_serial_byte_t next_command_byte;

  // A toggle edge means byte_hold has settled for several cycles.
  always_comb begin
    next_command_valid = tog_sync[1] != tog_prev;
    next_command_byte = command_byte;
    if (next_command_valid) begin
      next_command_byte = byte_hold;
    end
  end

  // Registers the received byte.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      command_valid <= 1'b0;
      command_byte <= '0;
    end else begin
      command_valid <= next_command_valid;
      command_byte <= next_command_byte;
    end
  end

  // ---------------- DAC registers ----------------

  logic [1:0] init_cnt; // Waits for the strap synchroniser to fill.
  logic [1:0] next_init_cnt;
  logic next_wake_to_ref;
  logic [DAC_CHANNELS-1:0][DAC_BITS-1:0] dac_input; // Input registers.
  logic [DAC_CHANNELS-1:0][DAC_BITS-1:0] next_dac_input;
  logic [DAC_CHANNELS-1:0][DAC_BITS-1:0] dac_held; // Output registers.

  // The strap is caught once, after release, never by the reset itself.
  always_comb begin
    next_init_cnt = init_cnt;
    next_wake_to_ref = dac_wake_to_ref;
    next_dac_input = dac_input;
    if (init_cnt != INIT_LOAD) begin
      next_init_cnt = init_cnt + 2'h1;
      if (init_cnt + 2'h1 == INIT_LOAD) begin
        next_wake_to_ref = wake_sync[1];
        for (int ch = 0; ch < DAC_CHANNELS; ch++) begin
          next_dac_input[ch] = wake_sync[1] ? DAC_FULL : DAC_ZERO;
        end
      end
    end else if (dac_write_valid) begin
      next_dac_input[dac_write.channel] = dac_write.code;
    end
  end

  // Registers the input registers and wake choice.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      init_cnt <= 2'h0;
      dac_wake_to_ref <= 1'b0;
      dac_input <= '0;
    end else begin
      init_cnt <= next_init_cnt;
      dac_wake_to_ref <= next_wake_to_ref;
      dac_input <= next_dac_input;
    end
  end

  // The load pin itself clocks the output registers, so no system edge
  // is involved; the host keeps input registers still around its rise.
  always_ff @(posedge dac_load_n or negedge reset_n) begin
    if (!reset_n) begin
      dac_held <= '0;
    end else begin
      dac_held <= dac_input;
    end
  end

  // While load is low the outputs follow the input registers directly.
  always_comb begin
    if (!dac_load_n) begin
      dac_outputs = dac_input;
    end else begin
      dac_outputs = dac_held;
    end
  end

endmodule

`default_nettype wire

// >>> verif/adsc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module adsc_host_model (
  // Serial pins toward the device.
  output logic sclk,
  output logic cs_n,
  output logic din,
  // Data back from the device.
  input wire logic dout,
  input wire logic dout_oe
);
  // Deselected with the clock parked; it never runs outside a frame.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // One frame of nb bits, MSB first; dout is taken just before the edge that moves it.
  task automatic xfer(input logic cpol, input logic m11, input logic [15:0] tx, input int nb,
                      output logic [15:0] rx);
    rx = '0;
    sclk = cpol;
    // The odd offset keeps every link edge off the system clock's edges when the call starts at an even time.
    #7 cs_n = 1'b0;
    #12;
    for (int i = 15; i > 15 - nb; i--) begin
      // Non-blocking, so a falling edge in this same step still takes the old bit.
      din <= tx[i];
      #6;
      if (m11 != cpol) rx[i] = dout_oe ? dout : 1'bz;
      sclk = ~sclk;
      #6;
      if (m11 == cpol) rx[i] = dout_oe ? dout : 1'bz;
      sclk = ~sclk;
      // A gap between bytes gives the system side time to pick each one up.
      if (i == 8) #200;
    end
    #6 cs_n = 1'b1;
    // A released line must not look as if it still held the last bit.
    din <= ~din;
  endtask
endmodule
`default_nettype wire

// >>> verif/adsc_serial_pin_ctrl_props.sv
`timescale 1ns/1ns
`default_nettype none
module adsc_pin_props
  import adsc_pkg::*;
(
  // Clocks and resets.
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  // Serial output.
  input wire logic dout,
  input wire logic dout_oe,
  // Conversion pins.
  input wire logic conversion_start_n,
  input wire logic [1:0] conversion_clock_mode,
  input wire logic conv_is_temp,
  input wire logic ref_on,
  input wire logic eoc_n,
  // DAC side.
  input wire logic dac_write_valid,
  input wire adsc_dac_write_t dac_write,
  input wire logic dac_load_n,
  input wire logic dac_wake_select,
  input wire logic dac_wake_to_ref,
  input wire logic [DAC_CHANNELS-1:0][DAC_BITS-1:0] dac_outputs
);
  // Limits from the start pin, with five cycles allowed for its synchroniser.
  localparam int VOLT_LIM = 230;
  localparam int TON_LIM = 1630;
  localparam int TOFF_LIM = 3505;
  logic run, eoc_q, start_q; // Conversion running, flags one cycle back.
  logic [12:0] busy; // Cycles since the start pin rose.
  logic [2:0] up; // Cycles since reset, saturating.
  logic rose_v, fell_v, d_rise, d_fall; // Output seen at the last edge of each kind.
  // A refused start leaves the count running, so a lost conversion still fires.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run <= 1'b0;
      eoc_q <= 1'b1;
      start_q <= 1'b1;
      busy <= '0;
      up <= '0;
    end else begin
      run <= (run && !(eoc_q && !eoc_n)) || (conversion_start_n && !start_q);
      eoc_q <= eoc_n;
      start_q <= conversion_start_n;
      busy <= run ? busy + 13'h1 : 13'h0;
      up <= (up == 3'h7) ? up : up + 3'h1;
    end
  end
  // Select high clears these, as it does the port.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rose_v <= 1'b0;
      d_rise <= 1'b0;
    end else begin
      rose_v <= 1'b1;
      d_rise <= dout;
    end
  end
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fell_v <= 1'b0;
      d_fall <= 1'b0;
    end else begin
      fell_v <= 1'b1;
      d_fall <= dout;
    end
  end
  // Done flag goes up soon after a start.
  sequence eoc_up;
    ##[1:6] eoc_n;
  endsequence
  sequence load_write;
    dac_write_valid && !dac_load_n && up == 3'h7 ##1 !dac_load_n;
  endsequence
  oe_cs_a: assert property (@(posedge clk) disable iff (!reset_n) dout_oe == !cs_n)
    else $error("output enable does not follow select");
  out_fall_a: assert property (@(negedge sclk) disable iff (cs_n)
    rose_v && conversion_clock_mode != CKMODE_11 |-> dout == d_rise) else $error("output moved on rise");
  out_rise_a: assert property (@(posedge sclk) disable iff (cs_n)
    fell_v && conversion_clock_mode == CKMODE_11 |-> dout == d_fall) else $error("output moved on fall");
  volt_time_a: assert property (@(posedge clk) disable iff (!reset_n)
    !conv_is_temp |-> busy <= VOLT_LIM) else $error("voltage conversion too long");
  temp_on_time_a: assert property (@(posedge clk) disable iff (!reset_n)
    conv_is_temp && ref_on |-> busy <= TON_LIM) else $error("temperature conversion too long");
  temp_off_time_a: assert property (@(posedge clk) disable iff (!reset_n)
    conv_is_temp && !ref_on |-> busy <= TOFF_LIM) else $error("cold temperature conversion too long");
  start_busy_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(conversion_start_n) && cs_n |-> eoc_up) else $error("done flag not raised at start");
  wake_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> ##[3:5] dac_wake_to_ref == dac_wake_select) else $error("wake state wrong");
  dac_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
    load_write |-> dac_outputs[$past(dac_write.channel)] == $past(dac_write.code))
    else $error("transparent output missed write");
  dac_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    dac_load_n && $past(dac_load_n) |-> $stable(dac_outputs)) else $error("held output moved");
endmodule
bind adsc_serial_pin_ctrl adsc_pin_props adsc_pin_props_inst (
  .clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe),
  .conversion_start_n(conversion_start_n), .conversion_clock_mode(conversion_clock_mode),
  .conv_is_temp(conv_is_temp), .ref_on(ref_on), .eoc_n(eoc_n), .dac_write_valid(dac_write_valid),
  .dac_write(dac_write), .dac_load_n(dac_load_n), .dac_wake_select(dac_wake_select),
  .dac_wake_to_ref(dac_wake_to_ref), .dac_outputs(dac_outputs)
);
`default_nettype wire

// >>> verif/test_adc_dac_serial_pin_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_adc_dac_serial_pin_control;
  import adsc_pkg::*;
  // Device pins, named as its ports.
  logic clk, reset_n, sclk, cs_n, din, dout, dout_oe, conversion_start_n, conv_is_temp, ref_on, eoc_n;
  logic command_valid, dac_write_valid, dac_load_n, dac_wake_select, dac_wake_to_ref;
  logic [1:0] conversion_clock_mode;
  logic [DAC_BITS-1:0] sample_data;
  adsc_serial_byte_t command_byte;
  adsc_dac_write_t dac_write;
  logic [DAC_CHANNELS-1:0][DAC_BITS-1:0] dac_outputs;
  // Tallies, timeout count and captured bytes.
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  int n, lim;
  logic [15:0] rx;
  adsc_serial_byte_t got_q[$];
  adsc_serial_pin_ctrl adsc_serial_pin_ctrl_inst (
    .clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
    .conversion_start_n(conversion_start_n), .conversion_clock_mode(conversion_clock_mode),
    .conv_is_temp(conv_is_temp), .ref_on(ref_on), .sample_data(sample_data), .eoc_n(eoc_n),
    .command_byte(command_byte), .command_valid(command_valid), .dac_write_valid(dac_write_valid),
    .dac_write(dac_write), .dac_load_n(dac_load_n), .dac_wake_select(dac_wake_select),
    .dac_wake_to_ref(dac_wake_to_ref), .dac_outputs(dac_outputs)
  );
  adsc_host_model adsc_host_model_inst (
    .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe)
  );
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Collects received bytes and cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (command_valid === 1'b1) got_q.push_back(command_byte);
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Write strobe of one cycle, then time for a transparent output to follow.
  task automatic dac_wr(input logic [1:0] ch, input logic [11:0] code);
    @(posedge clk);
    dac_write_valid <= 1'b1;
    dac_write <= '{channel: ch, code: code};
    @(posedge clk);
    dac_write_valid <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask
  initial begin
    {conv_is_temp, ref_on, dac_write_valid, dac_wake_select, reset_n} = '0;
    {conversion_start_n, dac_load_n} = 2'h3;
    conversion_clock_mode = CKMODE_00;
    sample_data = 12'h000;
    dac_write = '0;
    // Power-up codes for both strap levels.
    for (int s = 1; s >= 0; s--) begin
      dac_wake_select <= s[0];
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (5) @(posedge clk);
      chk(16'(dac_wake_to_ref), 16'(s));
      dac_load_n <= 1'b0;
      @(negedge clk);
      for (int c = 0; c < 4; c++) chk(16'(dac_outputs[c]), s ? 16'hfff : 16'h000);
      @(posedge clk) dac_load_n <= 1'b1;
      $display("test wake %0d done", s);
    end
    // Held outputs ignore writes; low load makes them follow.
    dac_wr(2'h2, 12'h5a3);
    chk(16'(dac_outputs[2]), 16'h000);
    @(posedge clk) dac_load_n <= 1'b0;
    @(negedge clk) chk(16'(dac_outputs[2]), 16'h5a3);
    dac_wr(2'h1, 12'h0c3);
    chk(16'(dac_outputs[1]), 16'h0c3);
    @(posedge clk) dac_load_n <= 1'b1;
    dac_wr(2'h1, 12'hfff);
    chk(16'(dac_outputs[1]), 16'h0c3);
    $display("test dac done");
    // Every clock mode for voltage, then both temperature cases; each result is read back.
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      conversion_clock_mode <= (k < 4) ? k[1:0] : k[1:0] - 2'h3;
      conv_is_temp <= (k > 3);
      ref_on <= (k == 4);
      sample_data <= 12'h9c5 + 12'(k);
      conversion_start_n <= 1'b0;
      lim = (k < 4) ? VOLT_MAX_CYCLES : (k == 4) ? TEMP_ON_CYCLES : TEMP_OFF_CYCLES;
      repeat (36) @(posedge clk);
      conversion_start_n <= 1'b1;
      n = 0;
      while (eoc_n !== 1'b0 && n < 4000) begin
        @(negedge clk);
        n++;
      end
      chk(16'(n <= lim + 6), 16'h1);
      adsc_host_model_inst.xfer(conversion_clock_mode[0], conversion_clock_mode == CKMODE_11,
                                {8'ha0 + 8'(k), 8'h3c}, 16, rx);
      chk(rx, {RESULT_PAD, 12'h9c5 + 12'(k)});
      chk(16'(eoc_n), 16'h1);
      repeat (8) @(posedge clk);
      chk(16'(got_q.size()), 16'h2);
      chk(16'(got_q[0]), {7'h0, 1'b1, 8'ha0 + 8'(k)});
      chk(16'(got_q[1]), {7'h0, 1'b0, 8'h3c});
      got_q.delete();
      // A frame cut short after four bits must leave nothing behind.
      adsc_host_model_inst.xfer(1'b0, 1'b0, 16'hffff, 4, rx);
      $display("test conversion %0d done", k);
    end
    stop_test();
  end
endmodule
`default_nettype wire
